// File: hdl/ombr_pkg.sv
// shared constants for the on-chip memory map and boot remap block
package ombr_pkg;
    // ==========================================================
    // memory map
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] ROM_BASE = 32'h0100_0000;
    localparam logic [31:0] ROM_SPAN = 32'h0100_0000;
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_BYTES_DEF = 32'h0008_0000;
    localparam int SRAM_BYTES_DEF = 49152;
    // api pointer table sits just past the rom vector table
    localparam logic [31:0] ROM_API_TABLE = 32'h0100_0010;
    // alias mapping: 32 alias bytes per sram byte, 4 per bit
    localparam int ALIAS_BYTE_SHIFT = 5;
    localparam int ALIAS_BIT_SHIFT = 2;
    // ==========================================================
    // boot sequence
    localparam logic [31:0] VEC_SP_ADDR = 32'h0000_0000;
    localparam logic [31:0] VEC_PC_ADDR = 32'h0000_0004;
    localparam logic [31:0] FLASH_EMPTY = 32'hffff_ffff;
    localparam logic OVERLAY_RESET = 1'b1;
    localparam int CFG_PIN_LSB = 0;
    localparam int CFG_PORT_LSB = 3;
    localparam int CFG_POL_BIT = 6;
    localparam int CFG_OFF_BIT = 7;
    localparam int CFG_WIDTH = 8;
    localparam int GPIO_PORTS = 8;
    localparam int GPIO_WIDTH = 64;
    // time for the pin synchroniser to settle after reset
    localparam int PIN_SETTLE_CYCLES = 4;
    // ==========================================================
    // access regions
    typedef enum logic [2:0] {
        OMBR_RG_NONE = 3'h0,
        OMBR_RG_SRAM = 3'h1,
        OMBR_RG_ALIAS = 3'h2,
        OMBR_RG_ROM = 3'h3,
        OMBR_RG_FLASH = 3'h4
    } ombr_region_t;
endpackage : ombr_pkg

// File: hdl/ombr_bank.sv
// one 32-bit wide sram bank built from flip-flops
`timescale 1ns/100ps
`default_nettype none
module ombr_bank #(
    parameter int WORDS = 6144
) (
    input wire logic clock_i,
    input wire logic we_i,
    input wire logic [$clog2(WORDS)-1:0] idx_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    typedef struct packed {
        logic [WORDS-1:0][31:0] mem;
    } ombr_bank_state_t;

    ombr_bank_state_t st_reg;
    ombr_bank_state_t st_next;

    if (WORDS < 2) begin : g_words_check
        $error("bank needs at least two words");
    end

    // read is asynchronous so a bit update can be done in one cycle
    assign rdata_o = st_reg.mem[idx_i];

    always_comb begin
        st_next = st_reg;
        if (we_i) begin
            st_next.mem[idx_i] = wdata_i;
        end
    end

    // contents are not cleared; sram holds no defined value at power up
    always_ff @(posedge clock_i) begin
        st_reg <= st_next;
    end
endmodule : ombr_bank
`default_nettype wire

// File: hdl/ombr_top.sv
// sram front end with bit-band alias, bank stall and boot rom remap
//
// Overview of operation
// - sram is decoded from base address 2000_0000.
// - bit-band alias region for sram starts at 2200_0000.
// - alias address is alias base plus byte offset*32 plus bit*4.
// - alias accesses touch one sram bit atomically, no software rmw.
// - sram is two 32-bit banks: even words in one, odd in other.
// - read right after a write to the same bank stalls one cycle.
// - write then read of the other bank runs with no stall.
// - rom sits at 0100_0000 in normal operation.
// - after reset rom overlays flash so the rom boot runs first.
// - boot first clears the overlay: rom high, flash at zero.
// - pin check enabled and pin matches polarity: rom at zero, loader.
// - otherwise flash word 4 all ones: rom at zero, loader.
// - else stack pointer from flash word 0, pc from word 4, start.
// - boot pin selectable among any gpio of ports a to h.
// - rom holds a two-level api pointer table at 0100_0010.
`timescale 1ns/100ps
`default_nettype none
module ombr_top
    import ombr_pkg::*;
#(
    parameter int SRAM_BYTES = SRAM_BYTES_DEF,
    parameter logic [31:0] FLASH_BYTES = FLASH_BYTES_DEF
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic core_req_i,
    input wire logic core_we_i,
    input wire logic [31:0] core_addr_i,
    input wire logic [31:0] core_wdata_i,
    output logic core_ack_o,
    output logic core_err_o,
    output logic [31:0] core_rdata_o,
    output logic [2:0] core_region_o,
    input wire logic dma_req_i,
    input wire logic dma_we_i,
    input wire logic [31:0] dma_addr_i,
    input wire logic [31:0] dma_wdata_i,
    output logic dma_ack_o,
    output logic dma_err_o,
    output logic [31:0] dma_rdata_o,
    input wire logic [CFG_WIDTH-1:0] boot_select_config_i,
    input wire logic [GPIO_WIDTH-1:0] gpio_i,
    output logic flash_req_o,
    output logic [31:0] flash_addr_o,
    input wire logic flash_ack_i,
    input wire logic [31:0] flash_rdata_i,
    output logic rom_overlay_o,
    output logic rom_at_zero_o,
    output logic boot_done_o,
    output logic boot_loader_o,
    output logic [31:0] boot_sp_o,
    output logic [31:0] boot_pc_o
);
    localparam int BANK_WORDS = SRAM_BYTES / 8;
    localparam int IW = $clog2(BANK_WORDS);

    if (SRAM_BYTES % 8 != 0 || SRAM_BYTES < 16 || FLASH_BYTES > ROM_BASE) begin : g_size_check
        $error("sram must be a multiple of two words, flash must end below rom");
    end

    // ==========================================================
    // state
    typedef enum logic [5:0] {
        B_CLEAR = 6'h01,
        B_PIN = 6'h02,
        B_VEC1 = 6'h04,
        B_VEC0 = 6'h08,
        B_APP = 6'h10,
        B_LOADER = 6'h20
    } ombr_boot_t;

    typedef struct packed {
        logic [GPIO_WIDTH-1:0] sync1, sync2, sync3, pins;
        logic core_ack, core_err;
        logic [31:0] core_rdata;
        logic [2:0] core_region;
        logic dma_ack, dma_err;
        logic [31:0] dma_rdata;
        logic last_wr, last_wr_bank;
        ombr_boot_t boot;
        logic [2:0] settle;
        logic overlay, rom_zero, done, loader, flash_req;
        logic [31:0] flash_addr;
        logic [31:0] sp, pc;
    } ombr_state_t;

    ombr_state_t st_reg;
    ombr_state_t st_next;

    // ==========================================================
    // decode
    function automatic ombr_region_t region_of(input logic [31:0] a, input logic rom_low);
        ombr_region_t r;
        r = OMBR_RG_NONE;
        if (a >= SRAM_BASE && a < SRAM_BASE + 32'(SRAM_BYTES)) begin
            r = OMBR_RG_SRAM;
        end else if (a >= ALIAS_BASE && a < ALIAS_BASE + 32'(SRAM_BYTES * 32)) begin
            r = OMBR_RG_ALIAS;
        end else if (a >= ROM_BASE && a < ROM_BASE + ROM_SPAN) begin
            r = OMBR_RG_ROM;
        end else if (a < FLASH_BASE + FLASH_BYTES) begin
            r = rom_low ? OMBR_RG_ROM : OMBR_RG_FLASH;
        end
        return r;
    endfunction : region_of

    // byte offset into sram for either the direct or the alias window
    function automatic logic [31:0] sram_byte(input logic [31:0] a, input ombr_region_t r);
        logic [31:0] off;
        off = (r == OMBR_RG_ALIAS) ? ((a - ALIAS_BASE) >> ALIAS_BYTE_SHIFT)
                                   : (a - SRAM_BASE);
        return off;
    endfunction : sram_byte

    // ==========================================================
    // sram banks
    logic [1:0] bank_we;
    logic [IW-1:0] bank_idx;
    logic [31:0] bank_wdata;
    logic [1:0][31:0] bank_rdata;

    for (genvar g = 0; g < 2; g++) begin : g_bank
        ombr_bank #(
            .WORDS(BANK_WORDS)
        ) u_bank (
            .clock_i(clock_i),
            .we_i(bank_we[g]),
            .idx_i(bank_idx),
            .wdata_i(bank_wdata),
            .rdata_o(bank_rdata[g])
        );
    end

    // ==========================================================
    // access path
    logic core_pend, dma_pend, use_core, op_we, op_bank, op_is_sram, op_stall, op_err, pin_level;
    logic [31:0] op_addr, op_wdata, op_byte, op_word, op_rdata;
    ombr_region_t op_rg;
    logic [4:0] op_bit;
    logic [5:0] pin_sel;

    always_comb begin
        // an ack cycle still shows the old request, so it is not taken again
        core_pend = core_req_i && !st_reg.core_ack;
        dma_pend = dma_req_i && !st_reg.dma_ack;
        use_core = core_pend;
        op_we = use_core ? core_we_i : dma_we_i;
        op_addr = use_core ? core_addr_i : dma_addr_i;
        op_wdata = use_core ? core_wdata_i : dma_wdata_i;
        op_rg = region_of(op_addr, st_reg.overlay || st_reg.rom_zero);
        op_byte = sram_byte(op_addr, op_rg);
        op_bank = op_byte[2];
        bank_idx = op_byte[IW+2:3];
        op_bit = {op_byte[1:0], op_addr[4:ALIAS_BIT_SHIFT]};
        op_is_sram = (op_rg == OMBR_RG_SRAM) || (op_rg == OMBR_RG_ALIAS);
        // a same-bank read right behind a write waits one cycle
        op_stall = op_is_sram && !op_we && st_reg.last_wr
                   && (st_reg.last_wr_bank == op_bank);
        op_word = bank_rdata[op_bank];
        op_rdata = op_word;
        bank_wdata = op_wdata;
        if (op_rg == OMBR_RG_ALIAS) begin
            op_rdata = {31'h0000_0000, op_word[op_bit]};
            bank_wdata = op_word;
            bank_wdata[op_bit] = op_wdata[0];
        end
        // neither master is served outside sram; dma has no path to rom or flash
        op_err = !op_is_sram;
        bank_we = 2'h0;
        if ((core_pend || dma_pend) && op_is_sram && op_we) begin
            bank_we[op_bank] = 1'b1;
        end
        pin_sel = {boot_select_config_i[CFG_PORT_LSB +: 3], boot_select_config_i[CFG_PIN_LSB +: 3]};
        pin_level = st_reg.pins[pin_sel];
    end

    // ==========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        st_next.sync1 = gpio_i;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        for (int i = 0; i < GPIO_WIDTH; i++) begin
            if (st_reg.sync2[i] == st_reg.sync3[i]) begin
                st_next.pins[i] = st_reg.sync3[i];
            end
        end
        st_next.core_ack = 1'b0;
        st_next.dma_ack = 1'b0;
        st_next.last_wr = 1'b0;
        if ((core_pend || dma_pend) && !op_stall) begin
            st_next.last_wr = op_is_sram && op_we;
            st_next.last_wr_bank = op_bank;
            if (use_core) begin
                st_next.core_ack = 1'b1;
                st_next.core_err = op_err;
                st_next.core_rdata = (op_we || op_err) ? 32'h0000_0000 : op_rdata;
                st_next.core_region = op_rg;
            end else begin
                st_next.dma_ack = 1'b1;
                st_next.dma_err = op_err;
                st_next.dma_rdata = (op_we || op_err) ? 32'h0000_0000 : op_rdata;
            end
        end

        unique case (st_reg.boot)
            B_CLEAR: begin
                st_next.overlay = 1'b0;
                st_next.settle = 3'h0;
                st_next.boot = B_PIN;
            end
            B_PIN: begin
                // wait until the synchronised pin has settled before judging it
                if (st_reg.settle != 3'(PIN_SETTLE_CYCLES)) begin
                    st_next.settle = st_reg.settle + 3'h1;
                end else if (!boot_select_config_i[CFG_OFF_BIT]
                             && pin_level == boot_select_config_i[CFG_POL_BIT]) begin
                    st_next.rom_zero = 1'b1;
                    st_next.loader = 1'b1;
                    st_next.done = 1'b1;
                    st_next.boot = B_LOADER;
                end else begin
                    st_next.flash_req = 1'b1;
                    st_next.flash_addr = VEC_PC_ADDR;
                    st_next.boot = B_VEC1;
                end
            end
            B_VEC1: begin
                if (flash_ack_i) begin
                    st_next.flash_req = 1'b0;
                    if (flash_rdata_i == FLASH_EMPTY) begin
                        st_next.rom_zero = 1'b1;
                        st_next.loader = 1'b1;
                        st_next.done = 1'b1;
                        st_next.boot = B_LOADER;
                    end else begin
                        st_next.pc = flash_rdata_i;
                        st_next.boot = B_VEC0;
                    end
                end
            end
            B_VEC0: begin
                // request dropped for a cycle between the two vector reads
                if (!st_reg.flash_req) begin
                    st_next.flash_req = 1'b1;
                    st_next.flash_addr = VEC_SP_ADDR;
                end else if (flash_ack_i) begin
                    st_next.flash_req = 1'b0;
                    st_next.sp = flash_rdata_i;
                    st_next.done = 1'b1;
                    st_next.boot = B_APP;
                end
            end
            B_APP, B_LOADER: begin
                // both are final until the next reset
            end
            default: begin
                // an illegal code restarts the boot decision
                st_next.boot = B_CLEAR;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.overlay <= OVERLAY_RESET;
            st_reg.boot <= B_CLEAR;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs
    assign core_ack_o = st_reg.core_ack;
    assign core_err_o = st_reg.core_err;
    assign core_rdata_o = st_reg.core_rdata;
    assign core_region_o = st_reg.core_region;
    assign dma_ack_o = st_reg.dma_ack;
    assign dma_err_o = st_reg.dma_err;
    assign dma_rdata_o = st_reg.dma_rdata;
    assign flash_req_o = st_reg.flash_req;
    assign flash_addr_o = st_reg.flash_addr;
    assign rom_overlay_o = st_reg.overlay;
    assign rom_at_zero_o = st_reg.rom_zero;
    assign boot_done_o = st_reg.done;
    assign boot_loader_o = st_reg.loader;
    assign boot_sp_o = st_reg.sp;
    assign boot_pc_o = st_reg.pc;
endmodule : ombr_top
`default_nettype wire

// File: test/ombr_properties.sv
// concurrent checks on the ports of the memory map and boot remap block
`timescale 1ns/100ps
`default_nettype none
module ombr_properties
    import ombr_pkg::*;
#(
    parameter int SRAM_BYTES = SRAM_BYTES_DEF
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic core_req_i,
    input wire logic core_we_i,
    input wire logic [31:0] core_addr_i,
    input wire logic core_ack_o,
    input wire logic core_err_o,
    input wire logic [31:0] core_rdata_o,
    input wire logic [2:0] core_region_o,
    input wire logic dma_req_i,
    input wire logic dma_we_i,
    input wire logic [31:0] dma_addr_i,
    input wire logic dma_ack_o,
    input wire logic dma_err_o,
    input wire logic flash_req_o,
    input wire logic rom_overlay_o,
    input wire logic rom_at_zero_o,
    input wire logic boot_done_o,
    input wire logic boot_loader_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    function automatic logic in_sram(input logic [31:0] a);
        return a >= SRAM_BASE && a < SRAM_BASE + 32'(SRAM_BYTES);
    endfunction : in_sram
    function automatic logic in_alias(input logic [31:0] a);
        return a >= ALIAS_BASE && a < ALIAS_BASE + 32'(SRAM_BYTES * 32);
    endfunction : in_alias
    logic wr_done;
    logic rd_wait;
    assign wr_done = core_req_i && core_we_i && core_ack_o && in_sram(core_addr_i);
    assign rd_wait = dma_req_i && !dma_we_i && !dma_ack_o && in_sram(dma_addr_i);
    // ==========================================================
    // decode, boot and bank timing
    a_sram_decode: assert property (core_req_i && core_ack_o && in_sram(core_addr_i)
        |-> !core_err_o && core_region_o == OMBR_RG_SRAM) else $error("sram decode");
    a_alias_read: assert property (core_req_i && !core_we_i && core_ack_o
        && in_alias(core_addr_i) |-> core_rdata_o[31:1] == 31'h0 && !core_err_o)
        else $error("alias read");
    a_dma_sram_only: assert property (dma_req_i && dma_ack_o && !in_sram(dma_addr_i)
        && !in_alias(dma_addr_i) |-> dma_err_o) else $error("dma outside sram");
    a_rom_decode: assert property (core_req_i && core_ack_o && core_addr_i[31:24] == 8'h01
        |-> core_err_o && core_region_o == OMBR_RG_ROM) else $error("rom decode");
    a_overlay_clear: assert property (rom_overlay_o |=> !rom_overlay_o)
        else $error("overlay kept");
    a_loader_map: assert property (boot_done_o |-> rom_at_zero_o == boot_loader_o)
        else $error("loader map");
    a_done_hold: assert property (boot_done_o
        |=> boot_done_o && $stable(boot_loader_o) && !flash_req_o) else $error("boot done");
    a_stall_same: assert property (wr_done && rd_wait
        && core_addr_i[2] == dma_addr_i[2] |=> !dma_ack_o) else $error("no stall");
    a_nostall_other: assert property (wr_done && rd_wait
        && core_addr_i[2] != dma_addr_i[2] |=> dma_ack_o) else $error("extra stall");
endmodule : ombr_properties
bind ombr_top ombr_properties #(.SRAM_BYTES(SRAM_BYTES)) chk_u (
    .clock_i, .rst_b_i, .core_req_i, .core_we_i, .core_addr_i, .core_ack_o, .core_err_o,
    .core_rdata_o, .core_region_o, .dma_req_i, .dma_we_i, .dma_addr_i, .dma_ack_o,
    .dma_err_o, .flash_req_o, .rom_overlay_o, .rom_at_zero_o, .boot_done_o, .boot_loader_o
);
`default_nettype wire

// File: test/ombr_flash_model.sv
// flash read partner answering the boot vector fetches
`timescale 1ns/100ps
`default_nettype none
module ombr_flash_model (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic flash_req_i,
    input wire logic [31:0] flash_addr_i,
    input wire logic [31:0] word0_i,
    input wire logic [31:0] word4_i,
    input wire logic [1:0] delay_i,
    output logic flash_ack_o,
    output logic [31:0] flash_rdata_o
);
    logic [1:0] wait_cnt;
    // data toggles outside the ack so a stale word cannot pass
    always_ff @(posedge clock_i) begin
        flash_rdata_o <= ~flash_rdata_o;
        flash_ack_o <= 1'b0;
        if (!rst_b_i) begin
            flash_rdata_o <= 32'h5a3c_96e1;
            wait_cnt <= 2'h0;
        end else if (flash_ack_o || !flash_req_i) begin
            wait_cnt <= 2'h0;
        end else if (wait_cnt == delay_i) begin
            flash_ack_o <= 1'b1;
            flash_rdata_o <= (flash_addr_i == 32'h4) ? word4_i : word0_i;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule : ombr_flash_model
`default_nettype wire

// File: test/ombr_top_tb_top.sv
// self-checking bench for the memory map and boot remap block
`timescale 1ns/100ps
`default_nettype none
module ombr_top_tb_top;
    import ombr_pkg::*;
    localparam int SRAM_SIZE = 64;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic core_req_i = 1'b0;
    logic core_we_i = 1'b0;
    logic dma_req_i = 1'b0;
    logic dma_we_i = 1'b0;
    logic [31:0] core_addr_i = 32'h0;
    logic [31:0] core_wdata_i = 32'h0;
    logic [31:0] dma_addr_i = 32'h0;
    logic [31:0] dma_wdata_i = 32'h0;
    logic [7:0] boot_select_config_i = 8'h80;
    logic [63:0] gpio_i = 64'h0;
    logic [31:0] fw0 = 32'h0;
    logic [31:0] fw4 = 32'h0;
    logic [1:0] fdly = 2'h0;
    logic core_ack_o, core_err_o, dma_ack_o, dma_err_o, flash_req_o, flash_ack_i;
    logic rom_overlay_o, rom_at_zero_o, boot_done_o, boot_loader_o;
    logic [31:0] core_rdata_o, dma_rdata_o, flash_addr_o, flash_rdata_i, boot_sp_o, boot_pc_o;
    logic [2:0] core_region_o;
    logic [31:0] mem [16];
    logic [31:0] bad [3] = '{FLASH_BASE, ROM_API_TABLE, 32'h1000_0000};
    int fail_count = 0;
    int samples_checked = 0;
    always #5 clock_i = ~clock_i;
    ombr_top #(.SRAM_BYTES(SRAM_SIZE)) dut_u (
        .clock_i, .rst_b_i, .core_req_i, .core_we_i, .core_addr_i, .core_wdata_i, .core_ack_o,
        .core_err_o, .core_rdata_o, .core_region_o, .dma_req_i, .dma_we_i, .dma_addr_i,
        .dma_wdata_i, .dma_ack_o, .dma_err_o, .dma_rdata_o, .boot_select_config_i, .gpio_i,
        .flash_req_o, .flash_addr_o, .flash_ack_i, .flash_rdata_i, .rom_overlay_o,
        .rom_at_zero_o, .boot_done_o, .boot_loader_o, .boot_sp_o, .boot_pc_o
    );
    ombr_flash_model flash_u (
        .clock_i, .rst_b_i, .flash_req_i(flash_req_o), .flash_addr_i(flash_addr_o),
        .word0_i(fw0), .word4_i(fw4), .delay_i(fdly), .flash_ack_o(flash_ack_i),
        .flash_rdata_o(flash_rdata_i)
    );
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check
    // ==========================================================
    // bus cycle: hold until ack is sampled, then release with flipped lines
    task automatic bus_op(input logic dma, input logic we, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic er, output int lat);
        lat = 0;
        @(posedge clock_i);
        #1;
        if (dma)
            {dma_req_i, dma_we_i, dma_addr_i, dma_wdata_i} = {1'b1, we, a, wd};
        else
            {core_req_i, core_we_i, core_addr_i, core_wdata_i} = {1'b1, we, a, wd};
        do begin
            @(posedge clock_i);
            lat++;
        end while ((dma ? dma_ack_o : core_ack_o) !== 1'b1 && lat < 20);
        check("bus ack", 32'h1, {31'h0, dma ? dma_ack_o : core_ack_o});
        rd = dma ? dma_rdata_o : core_rdata_o;
        er = dma ? dma_err_o : core_err_o;
        #1;
        if (dma)
            {dma_req_i, dma_addr_i, dma_wdata_i} = {1'b0, ~a, ~wd};
        else
            {core_req_i, core_addr_i, core_wdata_i} = {1'b0, ~a, ~wd};
    endtask : bus_op
    task automatic sram_op(input logic dma, input logic we, input logic [31:0] a,
        input logic [31:0] wd);
        logic [31:0] rd;
        logic [31:0] exp;
        logic er;
        int lat;
        int ofs;
        int pos;
        bus_op(dma, we, a, wd, rd, er, lat);
        if (a >= ALIAS_BASE) begin
            ofs = int'((a - ALIAS_BASE) >> ALIAS_BYTE_SHIFT);
            pos = (ofs % 4) * 8 + int'(a[4:2]);
            exp = {31'h0, mem[ofs / 4][pos]};
            if (we) mem[ofs / 4][pos] = wd[0];
        end else begin
            exp = mem[a[5:2]];
            if (we) mem[a[5:2]] = wd;
        end
        if (!we) check("read data", exp, rd);
        check("sram error", 32'h0, {31'h0, er});
    endtask : sram_op
    task automatic boot_run(input logic [7:0] cfg, input logic [63:0] pins,
        input logic [31:0] w4, input logic ldr);
        logic [31:0] rd;
        logic er;
        int lat;
        @(posedge clock_i);
        #1;
        rst_b_i = 1'b0;
        boot_select_config_i = cfg;
        gpio_i = pins;
        fw4 = w4;
        fw0 = $urandom;
        fdly = 2'($urandom);
        repeat (4) @(posedge clock_i);
        #1;
        check("overlay in reset", 32'h1, {31'h0, rom_overlay_o});
        rst_b_i = 1'b1;
        while (boot_done_o !== 1'b1 && lat < 100) begin
            @(posedge clock_i);
            lat++;
        end
        #1;
        check("boot done", 32'h1, {31'h0, boot_done_o});
        check("loader", {31'h0, ldr}, {31'h0, boot_loader_o});
        check("overlay after", 32'h0, {31'h0, rom_overlay_o});
        if (!ldr) check("stack pointer", fw0, boot_sp_o);
        if (!ldr) check("program counter", w4, boot_pc_o);
        bus_op(1'b0, 1'b0, FLASH_BASE + 32'h8, 32'h0, rd, er, lat);
        check("low region", 32'(ldr ? OMBR_RG_ROM : OMBR_RG_FLASH),
            {29'h0, core_region_o});
    endtask : boot_run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        logic [31:0] rd, rd1, d;
        logic er, er1, pol, e;
        int lat, lat1, w, r, pin;
        logic [63:0] pins;
        void'($urandom(32'he5c0213f));
        // every port a to h, both polarities, check off, empty flash
        for (int i = 0; i < 10; i++) begin
            pol = 1'($urandom);
            pin = int'($urandom % 8);
            pins = {$urandom, $urandom};
            pins[(i % 8) * 8 + pin] = (i < 8 && i[0]) ? !pol : pol;
            e = i[1] || i == 9;
            boot_run({i >= 8, pol, 3'(i), 3'(pin)}, pins, e ? FLASH_EMPTY : $urandom >> 1,
                e || (i < 8 && !i[0]));
        end
        $display("test boot finished");
        for (int i = 0; i < 16; i++) begin
            sram_op(1'($urandom), 1'b1, SRAM_BASE + 32'(i * 4), $urandom);
        end
        for (int i = 0; i < 40; i++) begin
            d = ALIAS_BASE + 32'(($urandom % 512) * 4);
            sram_op(1'($urandom), 1'($urandom), d, $urandom);
        end
        for (int i = 0; i < 16; i++) begin
            sram_op(1'($urandom), 1'b0, SRAM_BASE + 32'(i * 4), 32'h0);
        end
        $display("test sram and alias finished");
        for (int i = 0; i < 8; i++) begin
            w = int'($urandom % 16);
            r = (w + (i[0] ? 2 : 1)) % 16;
            d = $urandom;
            fork
                bus_op(i[1], 1'b1, SRAM_BASE + 32'(w * 4), d, rd, er, lat);
                begin
                    @(posedge clock_i);
                    bus_op(!i[1], 1'b0, SRAM_BASE + 32'(r * 4), 32'h0, rd1, er1, lat1);
                end
            join
            mem[w] = d;
            check("read beside write", mem[r], rd1);
            check("read latency", i[0] ? 32'h3 : 32'h2, 32'(lat1));
        end
        $display("test bank stall finished");
        for (int i = 0; i < 3; i++) begin
            bus_op(1'b1, i[0], bad[i], $urandom, rd, er, lat);
            check("dma error", 32'h1, {31'h0, er});
            bus_op(1'b0, 1'b0, bad[i], 32'h0, rd, er, lat);
            check("core error", 32'h1, {31'h0, er});
            check("core region", 32'(i < 2 ? OMBR_RG_ROM : OMBR_RG_NONE),
                {29'h0, core_region_o});
        end
        $display("test errors finished");
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        end_of_test();
    end
endmodule : ombr_top_tb_top
`default_nettype wire
